// ### logic/dcv_control.sv
// control, event and interrupt logic of the 10-bit converter
// assumes register strobes and the start event are synchronous to clk
//
// Notes on behaviour
// - with pump_disable low the pump follows the supply level, with it high the pump stays off.
// - left_justify picks where the 10-bit code sits in the data word and staging word.
// - internal_out_en high routes the converter output to the comparator_block.
// - external_out_en high lets the output buffer drive analog_out_pin, low turns it off.
// - buffer_empty_event_out high emits one event pulse each time the staging word empties.
// - start_event_in high makes each start event with a full staging word move that word and start a conversion.
// - writing 1 to irq_enable_clear clears that enable, reading back through irq_enable_set.
// - writing 1 to the empty, underrun or crossing_done bit of irq_enable_set sets that enable.
// - the empty flag sets when the staging word moves to data and raises irq if enabled.
// - the empty flag clears on a written 1 or on a new staging word, a 0 does nothing.
// - the underrun flag sets on a start event with start_event_in high while the staging word is empty.
// - the underrun flag clears only on a written 1.
// - right justified the code is bits 9:0, left justified bits 15:6.
// - domain_crossing_pending is set while a register crossing runs and clears at its end.
// - staging word and data register form a two-stage queue loaded by register writes and advanced by the start event.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dcv_control (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic start_event,
  input wire logic low_supply,
  output logic buffer_empty_event,
  output logic conv_start,
  output logic [9:0] conv_code,
  output logic pump_on,
  output logic internal_out_en,
  output logic external_out_en,
  output logic irq
);

  // ==========================================================
  // helpers
  // ==========================================================
  // pulls the 10-bit code out of a word under the chosen justification
  function automatic logic [9:0] dcv_code(input logic [15:0] word, input logic left);
    logic [15:0] shifted;
    shifted = word >> dcv_pkg::LEFT_SHIFT;
    dcv_code = left ? shifted[9:0] : word[9:0];
  endfunction : dcv_code

  function automatic logic wr_at(input logic wr, input logic [3:0] a,
                                 input logic [3:0] target);
    wr_at = wr && (a == target);
  endfunction : wr_at

  // ==========================================================
  // configuration registers
  // ==========================================================
  dcv_pkg::dcv_options_t opt_q, opt_d;
  dcv_pkg::dcv_events_t evc_q, evc_d;
  dcv_pkg::dcv_irq_t ien_q, ien_d;

  always_comb begin
    opt_d = opt_q;
    evc_d = evc_q;
    ien_d = ien_q;
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_OUTPUT_OPTIONS)) begin
      opt_d = reg_wdata[3:0];
    end
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_EVENT_CONTROL)) begin
      evc_d = reg_wdata[1:0];
    end
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_IRQ_ENABLE_CLEAR)) begin
      ien_d = ien_q & ~reg_wdata[2:0];
    end
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_IRQ_ENABLE_SET)) begin
      ien_d = ien_q | reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      opt_q <= dcv_pkg::OPT_RESET[3:0];
      evc_q <= dcv_pkg::EVC_RESET;
      ien_q <= dcv_pkg::IRQ_RESET;
    end else begin
      opt_q <= opt_d;
      evc_q <= evc_d;
      ien_q <= ien_d;
    end
  end

  // ==========================================================
  // staging word and data register
  // ==========================================================
  // the staging word is committed by its high byte, so software must
  // write the low byte first; a lone low-byte write updates storage and starts a crossing but does not commit
  logic [15:0] stage_q, stage_d;
  logic [15:0] data_q, data_d;
  logic stage_full_q, stage_full_d;
  logic stage_commit;
  logic data_write;
  logic take_event;
  logic transfer;
  logic underrun_hit;

  always_comb begin
    stage_commit = wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_STAGING_HI);
    data_write = wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_DATA_LO) ||
                 wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_DATA_HI);
    take_event = start_event && evc_q.start_event_in;
    transfer = take_event && stage_full_q;
    underrun_hit = take_event && !stage_full_q;
    stage_d = stage_q;
    data_d = data_q;
    stage_full_d = stage_full_q;
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_STAGING_LO)) begin
      stage_d[7:0] = reg_wdata;
    end
    if (stage_commit) begin
      stage_d[15:8] = reg_wdata;
    end
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_DATA_LO)) begin
      data_d[7:0] = reg_wdata;
    end
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_DATA_HI)) begin
      data_d[15:8] = reg_wdata;
    end
    if (transfer) begin
      data_d = stage_q;
      stage_full_d = 1'b0;
    end
    // a commit in the transfer cycle refills the buffer at once
    if (stage_commit) begin
      stage_full_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage_q <= dcv_pkg::DATA_RESET;
      data_q <= dcv_pkg::DATA_RESET;
      stage_full_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      data_q <= data_d;
      stage_full_q <= stage_full_d;
    end
  end

  // ==========================================================
  // register crossing tracker
  // ==========================================================
  // the converter domain is modelled by a fixed crossing time; a write
  // during a crossing restarts it, so the busy bit covers the last write
  dcv_pkg::dcv_sync_t sync_q, sync_d;
  logic [3:0] sync_cnt_q, sync_cnt_d;
  logic sync_start;
  logic sync_done;

  always_comb begin
    sync_start = data_write || stage_commit ||
                 wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_STAGING_LO);
    sync_d = sync_q;
    sync_cnt_d = sync_cnt_q;
    sync_done = 1'b0;
    unique case (sync_q)
      dcv_pkg::DCV_SYNC_IDLE: begin
        if (sync_start) begin
          sync_d = dcv_pkg::DCV_SYNC_BUSY;
          sync_cnt_d = dcv_pkg::CROSSING_CYCLES;
        end
      end
      dcv_pkg::DCV_SYNC_BUSY: begin
        if (sync_start) begin
          sync_cnt_d = dcv_pkg::CROSSING_CYCLES;
        end else if (sync_cnt_q == 4'h1) begin
          sync_d = dcv_pkg::DCV_SYNC_IDLE;
          sync_cnt_d = 4'h0;
          sync_done = 1'b1;
        end else begin
          sync_cnt_d = sync_cnt_q - 4'h1;
        end
      end
      default: begin
        sync_d = dcv_pkg::DCV_SYNC_IDLE;
        sync_cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_q <= dcv_pkg::DCV_SYNC_IDLE;
      sync_cnt_q <= 4'h0;
    end else begin
      sync_q <= sync_d;
      sync_cnt_q <= sync_cnt_d;
    end
  end

  // ==========================================================
  // interrupt flags
  // ==========================================================
  // in every flag the hardware set wins over a clear in the same cycle
  dcv_pkg::dcv_irq_t flag_q, flag_d;
  logic [2:0] flag_clr;

  always_comb begin
    flag_clr = 3'h0;
    if (wr_at(reg_wr, reg_addr, dcv_pkg::ADDR_IRQ_FLAGS)) begin
      flag_clr = reg_wdata[2:0];
    end
    flag_d = flag_q & ~flag_clr;
    if (stage_commit) begin
      flag_d.empty = 1'b0;
    end
    if (transfer) begin
      flag_d.empty = 1'b1;
    end
    if (underrun_hit) begin
      flag_d.underrun = 1'b1;
    end
    if (sync_done) begin
      flag_d.crossing_done = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= dcv_pkg::IRQ_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        dcv_pkg::ADDR_OUTPUT_OPTIONS: rdata_d = {4'h0, opt_q};
        dcv_pkg::ADDR_EVENT_CONTROL: rdata_d = {6'h00, evc_q};
        dcv_pkg::ADDR_IRQ_ENABLE_CLEAR: rdata_d = {5'h00, ien_q};
        dcv_pkg::ADDR_IRQ_ENABLE_SET: rdata_d = {5'h00, ien_q};
        dcv_pkg::ADDR_IRQ_FLAGS: rdata_d = {5'h00, flag_q};
        dcv_pkg::ADDR_CONVERTER_STATE: begin
          rdata_d = 8'h00;
          rdata_d[dcv_pkg::STATE_CROSSING_PENDING] =
            (sync_q == dcv_pkg::DCV_SYNC_BUSY);
        end
        // data and staging words are write-only and unmapped reads give zero
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  logic [7:0] rdata_q;
  logic empty_evt_q, empty_evt_d;
  logic conv_start_q, conv_start_d;
  logic [9:0] code_q, code_d;
  logic pump_q, pump_d;
  logic int_en_q, int_en_d;
  logic ext_en_q, ext_en_d;
  logic irq_q, irq_d;

  always_comb begin
    empty_evt_d = transfer && evc_q.buffer_empty_event_out;
    conv_start_d = transfer;
    code_d = dcv_code(data_q, opt_q.left_justify);
    // pump follows the supply level unless software forces it off
    pump_d = !opt_q.pump_disable && low_supply;
    int_en_d = opt_q.internal_out_en;
    ext_en_d = opt_q.external_out_en;
    irq_d = |(flag_d & ien_d);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
      empty_evt_q <= 1'b0;
      conv_start_q <= 1'b0;
      code_q <= 10'h000;
      pump_q <= 1'b0;
      int_en_q <= 1'b0;
      ext_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      empty_evt_q <= empty_evt_d;
      conv_start_q <= conv_start_d;
      code_q <= code_d;
      pump_q <= pump_d;
      int_en_q <= int_en_d;
      ext_en_q <= ext_en_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign buffer_empty_event = empty_evt_q;
  assign conv_start = conv_start_q;
  assign conv_code = code_q;
  assign pump_on = pump_q;
  assign internal_out_en = int_en_q;
  assign external_out_en = ext_en_q;
  assign irq = irq_q;

endmodule : dcv_control

`default_nettype wire

// ### logic/dcv_pkg.sv
// package for the converter control, event and interrupt block
// assumes one 100 MHz clock and an 8-bit register port
package dcv_pkg;

  // register offsets
  localparam logic [3:0] ADDR_OUTPUT_OPTIONS = 4'h1;
  localparam logic [3:0] ADDR_EVENT_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE_SET = 4'h5;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_CONVERTER_STATE = 4'h7;
  localparam logic [3:0] ADDR_DATA_LO = 4'h8;
  localparam logic [3:0] ADDR_DATA_HI = 4'h9;
  localparam logic [3:0] ADDR_STAGING_LO = 4'hC;
  localparam logic [3:0] ADDR_STAGING_HI = 4'hD;

  // field positions
  localparam int OPT_EXTERNAL_OUT_EN = 0;
  localparam int OPT_INTERNAL_OUT_EN = 1;
  localparam int OPT_LEFT_JUSTIFY = 2;
  localparam int OPT_PUMP_DISABLE = 3;
  localparam int EVC_START_EVENT_IN = 0;
  localparam int EVC_BUFFER_EMPTY_EVENT_OUT = 1;
  localparam int IRQ_UNDERRUN = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_CROSSING_DONE = 2;
  localparam int STATE_CROSSING_PENDING = 7;
  localparam int LEFT_SHIFT = 6;

  // reset values and masks
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] OPT_MASK = 8'h0F;
  localparam logic [1:0] EVC_RESET = 2'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // timing of the register crossing into the converter clock domain
  localparam int CLK_PERIOD_NS = 10;
  localparam int CROSSING_TIME_NS = 30;
  localparam int CROSSING_CYCLES_INT =
    (CROSSING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CROSSING_CYCLES = CROSSING_CYCLES_INT[3:0];

  typedef struct packed {
    logic pump_disable;
    logic left_justify;
    logic internal_out_en;
    logic external_out_en;
  } dcv_options_t;

  typedef struct packed {
    logic buffer_empty_event_out;
    logic start_event_in;
  } dcv_events_t;

  typedef struct packed {
    logic crossing_done;
    logic empty;
    logic underrun;
  } dcv_irq_t;

  typedef enum logic [1:0] {
    DCV_SYNC_IDLE = 2'b01,
    DCV_SYNC_BUSY = 2'b10
  } dcv_sync_t;

endpackage : dcv_pkg

// ### test/dcv_control_monitor.sv
// checker for the converter control block, watching its top ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module dcv_control_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd,
  input wire logic start_event,
  input wire logic low_supply,
  input wire logic buffer_empty_event,
  input wire logic conv_start,
  input wire logic [9:0] conv_code,
  input wire logic pump_on,
  input wire logic internal_out_en,
  input wire logic external_out_en
);
  // ==========================================
  // shadow of the option and event registers
  logic [3:0] opt_q;
  logic [1:0] evc_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      opt_q <= 4'h0;
      evc_q <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == dcv_pkg::ADDR_OUTPUT_OPTIONS) opt_q <= reg_wdata[3:0];
      if (reg_addr == dcv_pkg::ADDR_EVENT_CONTROL) evc_q <= reg_wdata[1:0];
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // outputs lag one cycle, so the cycle leaving reset is skipped
  sequence s_run; !$past(srst); endsequence
  sequence s_taken; $past(start_event) && $past(evc_q[0]); endsequence
  sequence s_quiet; !$past(start_event, 2) && !$past(reg_wr, 2); endsequence

  a_pump_auto: assert property (s_run |-> pump_on == $past(!opt_q[3] && low_supply))
    else $error("pump output does not follow supply and option");
  a_internal_path: assert property (s_run |-> internal_out_en == $past(opt_q[1]))
    else $error("internal output enable wrong");
  a_external_path: assert property (s_run |-> external_out_en == $past(opt_q[0]))
    else $error("external output enable wrong");
  a_start_gate: assert property (conv_start |-> s_taken)
    else $error("conversion started without an enabled start event");
  a_empty_evt_gate: assert property (buffer_empty_event |-> conv_start && $past(evc_q[1]))
    else $error("empty event without enabled transfer");
  a_empty_evt_each: assert property (conv_start && $past(evc_q[1]) |-> buffer_empty_event)
    else $error("empty event missing on transfer");
  a_code_hold: assert property (s_quiet |-> $stable(conv_code))
    else $error("converter code changed without a cause");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : dcv_control_monitor

`default_nettype wire

// ### test/dcv_tb.sv
// self-checking bench for the converter control block
// assumes the design package and the port checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic start_event = 1'b0;
  logic low_supply = 1'b1;
  logic [7:0] reg_rdata;
  logic buffer_empty_event, conv_start, pump_on, internal_out_en, external_out_en, irq;
  logic [9:0] conv_code;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  dcv_control dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_event(start_event),
    .low_supply(low_supply), .buffer_empty_event(buffer_empty_event),
    .conv_start(conv_start), .conv_code(conv_code), .pump_on(pump_on),
    .internal_out_en(internal_out_en), .external_out_en(external_out_en), .irq(irq));

  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  task automatic pulse;
    @(posedge clk);
    start_event <= 1'b1;
    @(posedge clk);
    start_event <= 1'b0;
    #1;
  endtask : pulse

  task automatic outs(input logic [2:0] exp);
    repeat (2) @(posedge clk);
    #1;
    chk({13'h0, pump_on, internal_out_en, external_out_en}, {13'h0, exp});
  endtask : outs

  // ==========================================
  // scenarios
  task automatic s_reset;
    logic [3:0] a [7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h3};
    foreach (a[i]) rd(a[i], 8'h00);
  endtask : s_reset

  task automatic s_options;
    wr(4'h1, 8'h0F);
    rd(4'h1, 8'h0F);
    outs(3'b011);
    wr(4'h1, 8'h08);
    outs(3'b000);
    wr(4'h1, 8'h03);
    outs(3'b111);
    @(posedge clk);
    low_supply <= 1'b0;
    outs(3'b011);
  endtask : s_options

  task automatic s_enables;
    wr(4'h5, 8'h07);
    rd(4'h5, 8'h07);
    rd(4'h4, 8'h07);
    wr(4'h4, 8'h00);
    rd(4'h5, 8'h07);
    wr(4'h4, 8'h02);
    rd(4'h5, 8'h05);
    wr(4'h4, 8'h05);
    rd(4'h4, 8'h00);
  endtask : s_enables

  task automatic s_underrun;
    wr(4'h2, 8'h00);
    pulse();
    rd(4'h6, 8'h00);
    wr(4'h2, 8'h03);
    pulse();
    rd(4'h6, 8'h01);
    chk({15'h0, irq}, 16'h0000);
    wr(4'h5, 8'h01);
    chk({15'h0, irq}, 16'h0001);
    wr(4'h6, 8'h00);
    rd(4'h6, 8'h01);
    wr(4'h6, 8'h01);
    rd(4'h6, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    wr(4'h4, 8'h01);
  endtask : s_underrun

  // the second call also proves that a new staging word drops a set empty flag
  task automatic s_transfer(input logic [7:0] opt, input logic [7:0] lo, input logic [7:0] hi);
    wr(4'h1, opt);
    wr(4'h5, 8'h02);
    wr(4'hC, lo);
    wr(4'hD, hi);
    rd(4'h7, 8'h80);
    repeat (4) @(posedge clk);
    rd(4'h7, 8'h00);
    rd(4'h6, 8'h04);
    wr(4'h6, 8'h04);
    chk({15'h0, irq}, 16'h0000);
    pulse();
    chk({13'h0, conv_start, buffer_empty_event, irq}, 16'h0007);
    @(posedge clk);
    #1;
    chk({6'h00, conv_code}, 16'h03A5);
    rd(4'h6, 8'h02);
    wr(4'h4, 8'h02);
    chk({15'h0, irq}, 16'h0000);
  endtask : s_transfer

  // direct data write, crossing_done irq, software clear of empty, gated events
  task automatic s_drain;
    wr(4'h2, 8'h01);
    wr(4'h5, 8'h04);
    wr(4'h8, 8'h12);
    rd(4'h7, 8'h80);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0001);
    chk({6'h00, conv_code}, 16'h03A4);
    wr(4'h6, 8'h04);
    chk({15'h0, irq}, 16'h0000);
    wr(4'h4, 8'h04);
    rd(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    rd(4'h6, 8'h02);
    wr(4'h6, 8'h02);
    rd(4'h6, 8'h00);
    wr(4'hC, 8'h01);
    wr(4'hD, 8'h00);
    wr(4'h2, 8'h00);
    pulse();
    chk({15'h0, conv_start}, 16'h0000);
    wr(4'h2, 8'h01);
    pulse();
    chk({13'h0, conv_start, buffer_empty_event, irq}, 16'h0004);
    pulse();
    rd(4'h6, 8'h07);
  endtask : s_drain

  // ==========================================
  // run control
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    s_reset();
    s_options();
    s_enables();
    s_underrun();
    s_transfer(8'h03, 8'hA5, 8'h03);
    s_transfer(8'h07, 8'h40, 8'hE9);
    s_drain();
    print_verdict();
  end
endmodule : tb

bind dcv_control dcv_control_monitor mon (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_rd(reg_rd),
  .start_event(start_event), .low_supply(low_supply),
  .buffer_empty_event(buffer_empty_event), .conv_start(conv_start), .conv_code(conv_code),
  .pump_on(pump_on), .internal_out_en(internal_out_en), .external_out_en(external_out_en));

`default_nettype wire
